/* isp_sensor_port.sv */
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "isp_regs.svh"
module isp_sensor_port
  import isp_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        scl,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        bridge_fault,
  input  wire logic        supply_fault
);
  isp_st_s q;             // Registered state
  isp_st_s n;             // Next state
  logic    scl_rise;      // Filtered clock line edges
  logic    scl_fall;
  logic    start_c;       // Bus conditions
  logic    stop_c;
  logic    byte_end;      // Falling edge after eighth bit
  logic    addr_hit;      // Our address pair
  logic [3:0] c4_nxt;     // Checksum step outputs
  logic [7:0] c8_nxt;
  logic [7:0] cfg_nxt;
  logic [7:0] cfg_in;

  // A change counts once second and third stages agree
  assign scl_rise = (q.scl_sy[1] == q.scl_sy[2]) && q.scl_sy[2] && !q.scl_f;
  assign scl_fall = (q.scl_sy[1] == q.scl_sy[2]) && !q.scl_sy[2] && q.scl_f;
  assign start_c  = (q.sda_sy[1] == q.sda_sy[2]) && !q.sda_sy[2] && q.sda_f
                    && q.scl_f && !scl_fall;
  assign stop_c   = (q.sda_sy[1] == q.sda_sy[2]) && q.sda_sy[2] && !q.sda_f
                    && q.scl_f && !scl_fall;
  assign byte_end = scl_fall && q.cnt == 4'd8;
  assign addr_hit = q.sh[7:2] == 6'(`ISP_DEV_ADDR >> 1);
  // Configuration check restarts from its seed
  assign cfg_in   = (q.cfg_cnt == 7'd0) ? `ISP_C8_INIT : q.cfg_crc;

  // Frame check, data check and configuration check
  isp_crc_step #(.W(4), .POLY(`ISP_C4_POLY)) u_c4 (
    .crc (q.c4),
    .din (q.sda_f),
    .nxt (c4_nxt)
  ); // RULE10
  isp_crc_step #(.W(8), .POLY(`ISP_C8_POLY)) u_c8 (
    .crc (q.c8),
    .din (q.sda_f),
    .nxt (c8_nxt)
  ); // RULE11
  isp_crc_step #(.W(8), .POLY(`ISP_C8_POLY)) u_cfg (
    .crc (cfg_in),
    .din (1'((`ISP_NVM_IMAGE >> (7'd63 - q.cfg_cnt)) & 64'h1)),
    .nxt (cfg_nxt)
  ); // RULE18

  // Byte seen by the master at a byte address
  function automatic logic [7:0] get(isp_st_s s, logic [7:0] a);
    logic [15:0] w;
    w = s.mem[a[5:1]];
    if (a[7:1] == `ISP_A_STAT >> 1 || a[7:1] == `ISP_A_SYNC >> 1) begin
      w = s.status;
    end
    return a[0] ? w[15:8] : w[7:0]; // RULE7
  endfunction

  // Store one byte written by the master
  function automatic isp_st_s put(isp_st_s s, logic [7:0] a, logic [7:0] d);
    isp_st_s r;
    r = s;
    if (a[7:1] == `ISP_A_DSPT >> 1 || a[7:1] == `ISP_A_DSPS >> 1) begin
      // Results are read-only from the serial side
    end else if (a[7:1] == `ISP_A_STAT >> 1) begin
      // Events clear on writing ones
      r.status[{a[0], 3'b000} +: 8] = s.status[{a[0], 3'b000} +: 8] & ~d;
    end else begin
      r.mem[a[5:1]][{a[0], 3'b000} +: 8] = d;
      // High byte of the command word acts
      if (a == `ISP_A_CMD + 8'd1 &&
          {d, s.mem[a[5:1]][7:0]} == `ISP_SLEEP_CODE) begin
        r.sleep = 1'b1; // RULE14
      end
    end
    return r;
  endfunction

  // Temperature in tenths of a degree to counts, saturated
  function automatic logic [15:0] tconv(logic signed [15:0] t10);
    int v;
    v = int'(t10) * `ISP_T_SLOPE_X10 / 100 + `ISP_T_OFFSET; // RULE21
    if (v > 32767) begin
      v = 32767;
    end else if (v < -32768) begin
      v = -32768;
    end
    return 16'(v);
  endfunction

  // Next state of the whole block
  always_comb begin
    logic [7:0] b;
    b = 8'h00;
    n = q;
    n.scl_sy = {q.scl_sy[1:0], scl};
    n.sda_sy = {q.sda_sy[1:0], sda_i};
    if (q.scl_sy[1] == q.scl_sy[2]) begin
      n.scl_f = q.scl_sy[2];
    end
    if (q.sda_sy[1] == q.sda_sy[2]) begin
      n.sda_f = q.sda_sy[2];
    end
    // A rising clock line edge ends sleep, except in the frame that sent it
    if (scl_rise && q.state != ST_SKIP) begin
      n.sleep = 1'b0; // RULE15
    end

    // Serial frame engine
    if (start_c) begin
      // Start or repeated start, either frame type
      n.state = ST_DEV; // RULE6
      n.cnt   = 4'd0;
      n.oe    = 1'b0;
      n.c4    = `ISP_C4_INIT; // RULE10
    end else if (stop_c) begin
      n.state = ST_IDLE;
      n.oe    = 1'b0;
    end else if (scl_rise && q.state != ST_IDLE && q.state != ST_SKIP) begin
      n.cnt = q.cnt + 4'd1;
      if (q.cnt < 4'd8) begin
        // Bits arrive MSB first
        n.sh = {q.sh[6:0], q.sda_f}; // RULE7
        // Frame check covers address, memory address, length
        if (q.state == ST_DEV || q.state == ST_MADDR ||
            (q.state == ST_LEN && q.cnt < 4'd4)) begin
          n.c4 = c4_nxt; // RULE12
        end
        // Data check over data bytes in wire order
        if (q.crcm && ((q.state == ST_WDATA && q.nbytes <= {1'b0, q.len}) ||
            (q.state == ST_RDATA && q.nbytes <= 5'({1'b0, q.len} + 5'd1)))) begin
          n.c8 = c8_nxt; // RULE12
        end
      end else if (q.state == ST_RDATA) begin
        // Master acknowledge bit, high ends the read
        n.mnack = q.sda_f;
      end
    end else if (scl_fall && q.state != ST_IDLE && q.state != ST_SKIP) begin
      if (q.cnt == 4'd8) begin
        if (q.state == ST_RDATA) begin
          // Release for the master acknowledge
          n.oe = 1'b0;
        end else begin
          n.oe = 1'b1;
          unique case (q.state)
            ST_DEV: begin
              if (addr_hit) begin
                n.crcm = q.sh[1]; // RULE5
                if (q.sh[0]) begin
                  // Read starts at the last address set
                  n.state  = ST_RDATA;
                  n.ptr    = q.last; // RULE3
                  n.nbytes = 5'd0;
                  n.mnack  = 1'b0;
                  n.c8     = `ISP_C8_INIT; // RULE11
                end else begin
                  n.state = ST_MADDR;
                end
              end else begin
                // Not ours: no acknowledge
                n.state = ST_SKIP; // RULE5
                n.oe    = 1'b0;
              end
            end
            ST_MADDR: begin
              n.ptr    = q.sh; // RULE1
              n.last   = q.sh; // RULE2
              n.nbytes = 5'd0;
              n.bad    = 1'b0;
              n.state  = q.crcm ? ST_LEN : ST_WDATA;
            end
            ST_LEN: begin
              n.len   = q.sh[7:4]; // RULE8
              n.c8    = `ISP_C8_INIT;
              n.state = ST_WDATA;
              // Low nibble carries the frame check
              if (q.sh[3:0] != q.c4) begin
                n.bad = 1'b1; // RULE22
                n.status[`ISP_ST_CRC] = 1'b1; // RULE13
              end
            end
            ST_WDATA: begin
              if (!q.crcm) begin
                // Plain frame: store as it comes, no limit
                n = put(n, q.ptr, q.sh); // RULE1
                n.ptr = q.ptr + 8'd1;
                // Sleep ends the frame, so its own clock pulses do not wake it
                if (n.sleep && !q.sleep) begin
                  n.state = ST_SKIP; // RULE14
                end
              end else if (q.nbytes <= {1'b0, q.len}) begin
                // Checked frame: hold data until its check
                if (q.nbytes < 5'd4) begin
                  n.wbuf[q.nbytes[1:0]] = q.sh;
                end
                n.nbytes = q.nbytes + 5'd1;
              end else begin
                n.state = ST_SKIP;
                if (q.sh != q.c8) begin
                  n.status[`ISP_ST_CRC] = 1'b1; // RULE13
                end else if (!q.bad && q.len <= `ISP_WR_LEN_MAX) begin
                  // Commit only a good frame within four bytes
                  for (int i = 0; i < 4; i++) begin
                    if (i <= int'(q.len)) begin
                      n = put(n, q.ptr + 8'(i), q.wbuf[i]); // RULE23
                    end
                  end
                end
              end
            end
            default: begin
              n.oe = 1'b0;
            end
          endcase
        end
      end else if (q.cnt == 4'd9) begin
        n.cnt = 4'd0;
        n.oe  = 1'b0;
        if (q.state == ST_RDATA) begin
          if (q.mnack) begin
            n.state = ST_SKIP;
          end else begin
            // Data, then data check, then idle ones
            if (q.crcm && q.nbytes == 5'({1'b0, q.len} + 5'd1)) begin
              b = q.c8; // RULE22
            end else if (q.crcm && q.nbytes > 5'({1'b0, q.len} + 5'd1)) begin
              b = 8'hff; // RULE9
            end else begin
              b = get(q, q.ptr); // RULE2
              n.ptr = q.ptr + 8'd1;
            end
            n.oe  = ~b[7]; // RULE7
            n.txs = {b[6:0], 1'b0};
            if (q.nbytes != 5'h1f) begin
              n.nbytes = q.nbytes + 5'd1;
            end
          end
        end
      end else if (q.state == ST_RDATA) begin
        // Next bit, pulling low for zeros
        n.oe  = ~q.txs[7];
        n.txs = {q.txs[6:0], 1'b0};
      end
    end else if (scl_fall && q.state == ST_SKIP) begin
      // Ignored bytes: a last acknowledge is dropped at the next fall
      n.oe = 1'b0;
    end

    // Power-up configuration check, one bit per cycle
    if (!q.cfg_done) begin
      n.cfg_crc = cfg_nxt;
      n.cfg_cnt = q.cfg_cnt + 7'd1;
      if (q.cfg_cnt == `ISP_NVM_BITS - 7'd1) begin
        n.cfg_done = 1'b1;
        // Residue is zero when the stored check matches
        n.cfg_ok   = cfg_nxt == 8'h00; // RULE18
        n.status[`ISP_ST_CFGERR] = cfg_nxt != 8'h00;
      end
    end

    // Bus slave: zero wait, always OKAY
    n.hready = 1'b1;
    n.h_act  = 1'b0;
    if (hsel && htrans[1] && hready) begin
      n.h_act  = 1'b1;
      n.h_wr   = hwrite;
      n.h_addr = haddr[7:0];
      n.hrdata = 32'h0000_0000;
      if (!hwrite) begin
        unique case (haddr[7:0])
          `ISP_H_STAT: n.hrdata = {13'h0000, q.sleep, q.cfg_ok, q.cfg_done, q.status};
          `ISP_H_TEMP: n.hrdata = {16'h0000, q.mem[5'(`ISP_A_DSPT >> 1)]};
          `ISP_H_PRESS: n.hrdata = {16'h0000, q.mem[5'(`ISP_A_DSPS >> 1)]};
          default: n.hrdata = 32'h0000_0000;
        endcase
      end
    end
    // Result updates come after serial writes, so they win
    if (q.h_act && q.h_wr && q.cfg_ok && !q.sleep) begin // RULE19
      if (q.h_addr == `ISP_H_TEMP) begin
        n.mem[5'(`ISP_A_DSPT >> 1)] = tconv(hwdata[15:0]);
        n.status[`ISP_ST_TUP] = 1'b1;
      end else if (q.h_addr == `ISP_H_PRESS) begin
        // Signed count passed through as is
        n.mem[5'(`ISP_A_DSPS >> 1)] = hwdata[15:0]; // RULE20
        n.status[`ISP_ST_SUP] = 1'b1; // RULE14
      end
    end
    // Monitor events are sticky and beat a clear
    if (bridge_fault) begin
      n.status[`ISP_ST_BRIDGE] = 1'b1; // RULE16
    end
    if (supply_fault) begin
      n.status[`ISP_ST_SUPPLY] = 1'b1; // RULE17
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      // Filters start at the idle-high line level, so no false edge follows reset
      q.scl_sy <= 3'b111;
      q.sda_sy <= 3'b111;
      q.scl_f  <= 1'b1;
      q.sda_f  <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign hrdata    = q.hrdata;
  assign hreadyout = q.hready;
  assign hresp     = 1'b0 & q.hready;
  assign sda_o     = 1'b0 & q.oe;
  assign sda_oe    = q.oe;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_wake_on_edge: assert property (q.sleep && scl_rise && q.state != ST_SKIP |=> !q.sleep) // RULE15
    else $error("sleep not left on clock rise");
  a_foreign_addr: assert property (q.state == ST_DEV && byte_end && !addr_hit
    |=> !q.oe && q.state == ST_SKIP) // RULE5
    else $error("foreign address acknowledged");
  a_read_last_ptr: assert property (q.state == ST_DEV && byte_end && addr_hit && q.sh[0]
    |=> q.ptr == $past(q.last) && q.state == ST_RDATA) // RULE3
    else $error("read not started at last address");
  a_crc4_event: assert property (q.state == ST_LEN && byte_end && q.sh[3:0] != q.c4
    |=> q.status[`ISP_ST_CRC] && q.bad) // RULE13
    else $error("frame check mismatch not flagged");
  a_bad_wr_kept: assert property (q.state == ST_WDATA && q.crcm && byte_end &&
    q.nbytes > {1'b0, q.len} && q.sh != q.c8
    |=> q.mem[q.ptr[5:1]] == $past(q.mem[q.ptr[5:1]]) && q.status[`ISP_ST_CRC]) // RULE23
    else $error("bad checked write changed data");
  a_cfg_fail_idle: assert property (q.cfg_done && !q.cfg_ok
    |-> !q.status[`ISP_ST_TUP] && !q.status[`ISP_ST_SUP]) // RULE19
    else $error("result flag set with bad configuration");
  a_bridge_flag: assert property (bridge_fault |=> q.status[`ISP_ST_BRIDGE][*2]) // RULE16
    else $error("bridge fault not held");
  a_supply_flag: assert property (supply_fault |=> q.status[`ISP_ST_SUPPLY]) // RULE17
    else $error("supply fault not flagged");
  a_sleep_no_data: assert property (q.sleep |=> !$rose(q.status[`ISP_ST_SUP])) // RULE14
    else $error("pressure updated while asleep");
endmodule
`default_nettype wire

/* isp_regs.svh */
`ifndef ISP_REGS_SVH
`define ISP_REGS_SVH
// What this block does
// RULE1: Random write stores bytes from set address
// RULE2: Random read returns bytes from set address
// RULE3: Address-less read restarts at last address
// RULE4: Master keeps word alignment, even byte counts
// RULE5: Address LSB picks plain or checked frame
// RULE6: Plain and checked frames mix freely
// RULE7: Words go low byte first, MSB first
// RULE8: Length nibble holds byte count minus one
// RULE9: Checked reads sixteen bytes, writes four
// RULE10: Frame check poly 0x03, start 0x0F
// RULE11: Data check poly 0xD5, start 0xFF
// RULE12: Checks run in bus bit order
// RULE13: Check mismatch sets link fault event
// RULE14: Sleep command stops new pressure data
// RULE15: Rising clock line wakes the device
// RULE16: Bridge fault sets bridge check flag
// RULE17: Bridge supply fault sets supply flag
// RULE18: Power-up checks configuration memory
// RULE19: Bad configuration never updates results
// RULE20: Pressure result is signed 16-bit
// RULE21: Temperature 397.2 counts/degree, offset -16881
// RULE22: Length and frame check, then data check
// RULE23: Bad checked write leaves registers unchanged

// Serial side
`define ISP_DEV_ADDR    7'h6c
`define ISP_A_CMD       8'h22
`define ISP_A_DSPT      8'h2e
`define ISP_A_DSPS      8'h30
`define ISP_A_SYNC      8'h32
`define ISP_A_STAT      8'h36
`define ISP_SLEEP_CODE  16'h6c32
`define ISP_C4_POLY     4'h3
`define ISP_C4_INIT     4'hf
`define ISP_C8_POLY     8'hd5
`define ISP_C8_INIT     8'hff
`define ISP_WR_LEN_MAX  4'h3
// Status bit positions
`define ISP_ST_TUP      0
`define ISP_ST_SUP      1
`define ISP_ST_CRC      2
`define ISP_ST_BRIDGE   3
`define ISP_ST_SUPPLY   4
`define ISP_ST_CFGERR   5
// Temperature transfer, slope times ten
`define ISP_T_SLOPE_X10 3972
`define ISP_T_OFFSET    (-16881)
// Configuration image, checksum in last byte
`define ISP_NVM_IMAGE   64'hff00000000000000
`define ISP_NVM_BITS    7'd64
// Bus offsets
`define ISP_H_STAT      8'h00
`define ISP_H_TEMP      8'h04
`define ISP_H_PRESS     8'h08
`endif

/* isp_pkg.sv */
`default_nettype none
package isp_pkg;
  // Serial port byte phases
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEV, ST_MADDR, ST_LEN, ST_WDATA, ST_RDATA, ST_SKIP
  } isp_state_e;

  // Whole block state
  typedef struct packed {
    logic [2:0]        scl_sy;
    logic [2:0]        sda_sy;
    logic              scl_f;
    logic              sda_f;
    isp_state_e        state;
    logic [3:0]        cnt;
    logic [7:0]        sh;
    logic [7:0]        txs;
    logic              crcm;
    logic [7:0]        ptr;
    logic [7:0]        last;
    logic [3:0]        len;
    logic              bad;
    logic [4:0]        nbytes;
    logic              mnack;
    logic [3:0]        c4;
    logic [7:0]        c8;
    logic [3:0][7:0]   wbuf;
    logic              oe;
    logic [31:0][15:0] mem;
    logic [15:0]       status;
    logic              sleep;
    logic [6:0]        cfg_cnt;
    logic [7:0]        cfg_crc;
    logic              cfg_done;
    logic              cfg_ok;
    logic              h_act;
    logic              h_wr;
    logic [7:0]        h_addr;
    logic [31:0]       hrdata;
    logic              hready;
  } isp_st_s;
endpackage
`default_nettype wire

/* isp_crc_step.sv */
`timescale 1ns/10ps
`default_nettype none
// One bit of an MSB-first checksum shift
module isp_crc_step #(
  parameter int           W    = 4,
  parameter logic [W-1:0] POLY = '0
) (
  input  wire logic [W-1:0] crc,
  input  wire logic         din,
  output logic      [W-1:0] nxt
);
  // Feedback from top bit xor incoming bit
  assign nxt = {crc[W-2:0], 1'b0} ^ ((crc[W-1] ^ din) ? POLY : '0);
endmodule
`default_nettype wire

/* isp_i2c_master.sv */
`timescale 1ns/10ps
`default_nettype none
// Stand-in for the outside bus master; clock and data idle high
module isp_i2c_master (
  input  wire logic sda_oe,
  output logic      scl,
  output wire logic sda
);
  localparam int Q = 40;  // Quarter of the 160 ns link period
  logic sda_pull;         // Master pulls data low
  // Open drain with pull-up: released line reads high
  assign sda = ~(sda_oe | sda_pull);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // One pulse; data set while low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_pull = ~b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  // Start or repeated start: data falls while clock high
  task automatic start();
    // Keep pin changes off the bus clock edges
    #1 sda_pull = 1'b0;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  // Stop: data rises while clock high, clock then stands still
  task automatic stop();
    sda_pull = 1'b1;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b0;
    #Q;
  endtask
  // Byte out, most significant bit first, then the device acknowledge
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // Byte in; master acknowledges all but the last
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask
  // Clock toggle outside a frame, data left high
  task automatic wake();
    #1 scl = 1'b0;
    #(2*Q) scl = 1'b1;
    #(2*Q);
  endtask
endmodule
`default_nettype wire

/* isp_sensor_port_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module isp_sensor_port_bench;
  logic        hclk, hresetn, hsel, hwrite, bridge_fault, supply_fault;
  logic [31:0] haddr, hwdata, hrdata, rd, p;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, sda_o, sda_oe, scl, sda, ok, ack;
  logic [7:0]  b8;
  logic [7:0]  em [0:63];    // Expected serial byte map
  logic [7:0]  q[$], rq[$];  // Bytes sent and bytes read back
  int          err_count, checks, seed, cyc, t10;

  isp_sensor_port dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .bridge_fault(bridge_fault), .supply_fault(supply_fault));
  isp_i2c_master mst_u (.sda_oe(sda_oe), .scl(scl), .sda(sda));

  // 200 MHz bus clock
  initial hclk = 1'b0;
  always #2.5 hclk = ~hclk;

  // Hang guard, well above the longest expected run
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_count++;
      complete_run();
    end
  end

  task complete_run();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Checksum steps, bits taken in bus order
  function automatic logic [7:0] c8(input logic [7:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'hd5 : 8'h00);
    return c;
  endfunction
  function automatic logic [3:0] c4(input logic [19:0] v);
    logic [3:0] c;
    c = 4'hf;
    for (int i = 19; i >= 0; i--) c = {c[2:0], 1'b0} ^ ((c[3] ^ v[i]) ? 4'h3 : 4'h0);
    return c;
  endfunction
  // Tenths of a degree to clamped result count
  function automatic logic [15:0] tconv(input int t);
    int v;
    v = t * 3972 / 100 - 16881;
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    return v[15:0];
  endfunction

  // Single word transfer; no fixed wait on ready
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task send(input logic [7:0] b, input logic e);
    mst_u.wbyte(b, ack);
    cmp(32'(ack), 32'(e));
  endtask

  // Whole serial frame; fix spoils the written data check byte
  task frame(input logic crc, input logic wr, input logic seta, input logic [7:0] a,
             input int n, input logic [7:0] fix);
    logic [7:0] b, c;
    c = 8'hff;
    mst_u.start();
    if (seta) begin
      send({6'h36, crc, 1'b0}, 1'b1);
      send(a, 1'b1);
      if (crc) send({4'(n - 1), c4({6'h36, crc, 1'b0, a, 4'(n - 1)})}, 1'b1);
    end
    if (wr) begin
      foreach (q[i]) send(q[i], 1'b1);
      foreach (q[i]) c = c8(c, q[i]);
      if (crc && fix != 8'h00) mst_u.wbyte(c ^ fix, ack);
      else if (crc) send(c, 1'b1);
    end else begin
      if (seta) mst_u.start();
      send({6'h36, crc, 1'b1}, 1'b1);
      rq = {};
      for (int i = 0; i < n + crc; i++) begin
        mst_u.rbyte(i == n + crc - 1, b);
        rq.push_back(b);
      end
      for (int i = 0; i < n; i++) c = c8(c, rq[i]);
      if (crc) cmp(32'(rq[n]), 32'(c));
    end
    mst_u.stop();
  endtask

  task chk_rd(input logic [7:0] a, input int n);
    for (int i = 0; i < n; i++) cmp(32'(rq[i]), 32'(em[a + i]));
  endtask

  // Main sequence
  initial begin
    seed = 35;
    cyc = 0;
    {hresetn, hsel, hwrite, bridge_fault, supply_fault} = '0;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'b010;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (80) @(posedge hclk);
    // Configuration image checked byte by byte, top byte first
    b8 = 8'hff;
    for (int i = 7; i >= 0; i--) b8 = c8(b8, 8'(64'hff00000000000000 >> (8 * i)));
    ok = (b8 == 8'h00);
    ahb(1'b0, 8'h00, 32'h0);
    cmp(32'(rd[17:16]), {30'h0, ok, 1'b1});
    ahb(1'b0, 8'h0c, 32'h0);
    cmp(rd, 32'h0);
    cmp(32'({hresp, sda_o}), 32'h0);
    // Results written, temperature read on both buses, pressure on the serial bus only, frame types alternating
    for (int k = 0; k < 3; k++) begin
      t10 = (k == 0) ? $random(seed) % 1250 : (k == 1 ? 1300 : -500);
      p = $random(seed);
      ahb(1'b1, 8'h04, 32'(t10));
      ahb(1'b1, 8'h08, p);
      {em[8'h2f], em[8'h2e]} = ok ? tconv(t10) : 16'h0;
      {em[8'h31], em[8'h30]} = ok ? p[15:0] : 16'h0;
      ahb(1'b0, 8'h04, 32'h0);
      cmp(rd, {16'h0, em[8'h2f], em[8'h2e]});
      ahb(1'b0, 8'h00, 32'h0);
      cmp(32'(rd[1:0]), {30'h0, ok, ok});
      frame(k[0], 1'b0, 1'b1, 8'h2e, 4, 8'h00);
      chk_rd(8'h2e, 4);
    end
    // Sixteen random bytes through plain and checked reads, the first four through a read-last
    q = {};
    for (int i = 0; i < 16; i++) begin
      b8 = 8'($random(seed));
      q.push_back(b8);
      em[8'h10 + i] = b8;
    end
    frame(1'b0, 1'b1, 1'b1, 8'h10, 16, 8'h00);
    frame(1'b0, 1'b0, 1'b1, 8'h10, 16, 8'h00);
    chk_rd(8'h10, 16);
    frame(1'b0, 1'b0, 1'b0, 8'h10, 4, 8'h00);
    chk_rd(8'h10, 4);
    frame(1'b1, 1'b0, 1'b1, 8'h10, 16, 8'h00);
    chk_rd(8'h10, 16);
    // Checked writes: good one lands, spoiled one is dropped
    q = {8'($random(seed)), 8'($random(seed))};
    {em[8'h15], em[8'h14]} = {q[1], q[0]};
    frame(1'b1, 1'b1, 1'b1, 8'h14, 2, 8'h00);
    q = {~q[0], ~q[1]};
    frame(1'b1, 1'b1, 1'b1, 8'h14, 2, 8'h01);
    frame(1'b0, 1'b0, 1'b1, 8'h14, 2, 8'h00);
    chk_rd(8'h14, 2);
    ahb(1'b0, 8'h00, 32'h0);
    cmp(32'(rd[2]), 32'h1);
    // Another bus address is ignored
    mst_u.start();
    send(8'he0, 1'b0);
    mst_u.stop();
    // Fault monitors, one pulse each, launched on a clock edge
    @(posedge hclk);
    bridge_fault <= 1'b1;
    @(posedge hclk);
    bridge_fault <= 1'b0;
    ahb(1'b0, 8'h00, 32'h0);
    cmp(32'(rd[4:3]), 32'h1);
    supply_fault <= 1'b1;
    @(posedge hclk);
    supply_fault <= 1'b0;
    ahb(1'b0, 8'h00, 32'h0);
    cmp(32'(rd[4:3]), 32'h3);
    // Sleep command, pressure frozen, clock edge wakes
    q = {8'h32, 8'h6c};
    frame(1'b0, 1'b1, 1'b1, 8'h22, 2, 8'h00);
    ahb(1'b0, 8'h00, 32'h0);
    cmp(32'(rd[18]), 32'h1);
    ahb(1'b1, 8'h08, ~p);
    ahb(1'b0, 8'h08, 32'h0);
    cmp(rd, {16'h0, em[8'h31], em[8'h30]});
    mst_u.wake();
    ahb(1'b0, 8'h00, 32'h0);
    cmp(32'(rd[18]), 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
